//--- core/icc_top.sv
// Behaviour
// - Capture selected time base on qualifying edge
// - Prescaled modes: every fourth, sixteenth rise
// - Mode 110 first edge set by bit
// - Narrow capture: timebase bit picks timer
// - Wide bit joins timers as 32 bits
// - Four-word buffer holds captures until read
// - Interrupt after one to four captures
// - Read-only overflow flag
// - Read-only buffer not empty flag
// - Enable clear resets and stops channel
// - Stop-in-idle halts channel during Idle
// - Capture edge wakes device from Sleep/Idle
// - Interrupt request on capture events
// - Unimplemented control bits read zero
//
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module icc_top
	import icc_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic CAPTURE_INPUT_PIN,
	input wire logic [15:0] FIRST_TIMEBASE,
	input wire logic [15:0] SECOND_TIMEBASE,
	input wire logic DEVICE_IDLE,
	input wire logic DEVICE_SLEEP,
	output logic CAPTURE_IRQ,
	output logic WAKE_REQUEST
);
	// ========================================
	// State
	typedef struct packed {
		logic [31:0] control;
		logic [IRQ_BITS-1:0] irq_status;
		logic [IRQ_BITS-1:0] irq_enable;
		logic pin_prev;
		logic first_done;
		logic [3:0] prescale;
		logic [1:0] event_count;
		logic overflow;
		logic ph_valid;
		logic ph_write;
		logic [7:0] ph_addr;
		logic [31:0] rdata;
		logic irq;
		logic wake;
	} icc_state_t;
	icc_state_t s_q, s_d;
	logic pin_sync;
	logic fifo_empty;
	logic fifo_full;
	logic [31:0] fifo_head;
	logic fifo_push;
	logic fifo_pop;
	logic [31:0] capture_value;
	logic running;
	logic enabled;
	logic rise;
	logic fall;
	logic any_edge;
	logic qualify;
	logic pop_read;
	icc_mode_t mode;
	icc_sync u_sync (
		.clk(CLOCK),
		.rst(RST),
		.din(CAPTURE_INPUT_PIN),
		.dout(pin_sync)
	);
	// ========================================
	// Capture path
	function automatic logic [31:0] pick_timebase(input logic wide, input logic sel,
		input logic [15:0] t_first, input logic [15:0] t_second);
		logic [31:0] r;
		r = 32'h0;
		if (wide) begin
			r = {t_second, t_first};
		end else if (sel) begin
			r = {16'h0, t_first};
		end else begin
			r = {16'h0, t_second};
		end
		return r;
	endfunction
	always_comb begin
		mode = icc_mode_t'(s_q.control[2:0]);
		enabled = s_q.control[BIT_ENABLE];
		// Halting in Idle freezes edge tracking too, so a pin change made during Idle fires as an edge on resume
		running = enabled && !(s_q.control[BIT_STOP_IN_IDLE] && DEVICE_IDLE);
		rise = pin_sync && !s_q.pin_prev;
		fall = !pin_sync && s_q.pin_prev;
		any_edge = rise || fall;
		capture_value = pick_timebase(s_q.control[BIT_WIDE], s_q.control[BIT_TIMEBASE],
			FIRST_TIMEBASE, SECOND_TIMEBASE);
		qualify = 1'b0;
		case (mode)
			ICC_MODE_EVERY_EDGE: qualify = any_edge;
			ICC_MODE_FALLING: qualify = fall;
			ICC_MODE_RISING: qualify = rise;
			ICC_MODE_RISE_4: qualify = rise && (s_q.prescale[1:0] == PRESCALE_4_LAST[1:0]);
			ICC_MODE_RISE_16: qualify = rise && (s_q.prescale == PRESCALE_16_LAST);
			ICC_MODE_EDGE_FIRST: begin
				if (s_q.first_done) begin
					qualify = any_edge;
				end else begin
					qualify = s_q.control[BIT_FIRST_EDGE] ? rise : fall;
				end
			end
			ICC_MODE_INT_ONLY: qualify = rise;
			default: qualify = 1'b0;
		endcase
		qualify = qualify && running;
		fifo_push = qualify && (mode != ICC_MODE_INT_ONLY);
	end
	icc_fifo u_fifo (
		.clk(CLOCK),
		.rst(RST),
		.flush(!enabled),
		.push(fifo_push),
		.push_data(capture_value),
		.pop(fifo_pop),
		.head(fifo_head),
		.empty(fifo_empty),
		.full(fifo_full)
	);
	// ========================================
	// Bus slave and channel state
	always_comb begin
		s_d = s_q;
		pop_read = 1'b0;
		fifo_pop = 1'b0;
		s_d.pin_prev = running ? pin_sync : s_q.pin_prev;
		if (qualify) begin
			if (mode == ICC_MODE_EDGE_FIRST) begin
				s_d.first_done = 1'b1;
			end
			if (fifo_full && fifo_push) begin
				s_d.overflow = 1'b1;
				s_d.irq_status[IRQ_OVERFLOW] = 1'b1;
			end else if (s_q.event_count == s_q.control[BIT_EPI_HI:BIT_EPI_LO]) begin
				s_d.event_count = 2'h0;
				s_d.irq_status[IRQ_CAPTURE] = 1'b1;
			end else begin
				s_d.event_count = s_q.event_count + 2'h1;
			end
		end
		if (rise && running) begin
			if (mode == ICC_MODE_RISE_4 || mode == ICC_MODE_RISE_16) begin
				// Every rise counts, not only the captured ones
				s_d.prescale = s_q.prescale + 4'h1;
			end else begin
				s_d.prescale = 4'h0;
			end
		end
		s_d.ph_valid = HSEL && HREADY && HTRANS[1];
		s_d.ph_write = HWRITE;
		s_d.ph_addr = HADDR[7:0];
		s_d.rdata = 32'h0;
		if (s_d.ph_valid && !HWRITE) begin
			if (HADDR[7:0] == ADDR_CONTROL) begin
				s_d.rdata = s_q.control & CONTROL_WRITE_MASK;
				s_d.rdata[BIT_OVERFLOW] = s_q.overflow;
				s_d.rdata[BIT_NOT_EMPTY] = !fifo_empty;
			end else if (HADDR[7:0] == ADDR_BUFFER) begin
				s_d.rdata = fifo_head;
				pop_read = 1'b1;
			end else if (HADDR[7:0] == ADDR_IRQ_STATUS) begin
				s_d.rdata = {30'h0, s_q.irq_status};
			end else if (HADDR[7:0] == ADDR_IRQ_ENABLE) begin
				s_d.rdata = {30'h0, s_q.irq_enable};
			end else begin
				s_d.rdata = 32'h0;
			end
		end
		fifo_pop = pop_read && !fifo_empty;
		if (s_q.ph_valid && s_q.ph_write) begin
			if (s_q.ph_addr == ADDR_CONTROL) begin
				s_d.control = HWDATA & CONTROL_WRITE_MASK;
			end else if (s_q.ph_addr == ADDR_IRQ_CLEAR) begin
				// Clear loses against a same-cycle event
				s_d.irq_status = s_q.irq_status & ~HWDATA[IRQ_BITS-1:0];
				if (qualify && fifo_full && fifo_push) begin
					s_d.irq_status[IRQ_OVERFLOW] = 1'b1;
				end
				if (qualify && s_d.event_count == 2'h0 && !(fifo_full && fifo_push)) begin
					s_d.irq_status[IRQ_CAPTURE] = 1'b1;
				end
			end else if (s_q.ph_addr == ADDR_IRQ_ENABLE) begin
				s_d.irq_enable = HWDATA[IRQ_BITS-1:0];
			end
		end
		if (!enabled) begin
			s_d.first_done = 1'b0;
			s_d.prescale = 4'h0;
			s_d.event_count = 2'h0;
			s_d.overflow = 1'b0;
			s_d.pin_prev = pin_sync;
		end
		s_d.irq = |(s_d.irq_status & s_d.irq_enable);
		s_d.wake = qualify && (DEVICE_SLEEP || DEVICE_IDLE);
	end
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign HRDATA = s_q.rdata;
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	assign CAPTURE_IRQ = s_q.irq;
	assign WAKE_REQUEST = s_q.wake;
	// ========================================
	// Checks
	a_unimpl_zero: assert property (@(posedge CLOCK) disable iff (RST)
		s_q.ph_valid && !s_q.ph_write && s_q.ph_addr == ADDR_CONTROL
		|-> HRDATA[31:16] == 16'h0 && HRDATA[14] == 1'b0 && HRDATA[12:10] == 3'h0)
		else $error("Unimplemented control bits not zero");
	a_overflow_set: assert property (@(posedge CLOCK) disable iff (RST)
		fifo_push && fifo_full && enabled |=> s_q.overflow)
		else $error("Overflow flag not set on full capture");
	a_full_keeps: assert property (@(posedge CLOCK) disable iff (RST)
		fifo_push && fifo_full && !fifo_pop && enabled |=> fifo_full && $stable(fifo_head))
		else $error("Full buffer changed by capture");
	a_disable_clears: assert property (@(posedge CLOCK) disable iff (RST)
		!enabled |=> fifo_empty && !s_q.overflow)
		else $error("Disabled channel kept state");
	a_idle_halt: assert property (@(posedge CLOCK) disable iff (RST)
		s_q.control[BIT_STOP_IN_IDLE] && DEVICE_IDLE |-> !fifo_push)
		else $error("Capture while halted in Idle");
	a_wake_edge: assert property (@(posedge CLOCK) disable iff (RST)
		qualify && DEVICE_SLEEP |=> WAKE_REQUEST)
		else $error("No wake on capture in Sleep");
	a_every_event: assert property (@(posedge CLOCK) disable iff (RST)
		qualify && s_q.control[6:5] == 2'h0 && !(fifo_full && fifo_push)
		|=> s_q.irq_status[IRQ_CAPTURE])
		else $error("Capture status not set every event");
	a_irq_level: assert property (@(posedge CLOCK) disable iff (RST)
		CAPTURE_IRQ == |(s_q.irq_status & s_q.irq_enable))
		else $error("Interrupt level does not follow enabled status");
	a_not_empty: assert property (@(posedge CLOCK) disable iff (RST)
		s_q.ph_valid && !s_q.ph_write && s_q.ph_addr == ADDR_CONTROL
		|-> HRDATA[BIT_NOT_EMPTY] == $past(!fifo_empty))
		else $error("Not-empty flag wrong");
	a_wide_value: assert property (@(posedge CLOCK) disable iff (RST)
		s_q.control[BIT_WIDE] |-> capture_value == {SECOND_TIMEBASE, FIRST_TIMEBASE})
		else $error("Wide capture value wrong");
	a_narrow_value: assert property (@(posedge CLOCK) disable iff (RST)
		!s_q.control[BIT_WIDE] |-> capture_value[31:16] == 16'h0
		&& capture_value[15:0] == (s_q.control[BIT_TIMEBASE] ? FIRST_TIMEBASE : SECOND_TIMEBASE))
		else $error("Narrow capture value wrong");
	a_prescale_step: assert property (@(posedge CLOCK) disable iff (RST)
		rise && running && (mode == ICC_MODE_RISE_4 || mode == ICC_MODE_RISE_16)
		|=> s_q.prescale == 4'($past(s_q.prescale) + 4'h1))
		else $error("Prescaler skipped a rising edge");
	a_prescale_last: assert property (@(posedge CLOCK) disable iff (RST)
		mode == ICC_MODE_RISE_16 && fifo_push |-> s_q.prescale == PRESCALE_16_LAST)
		else $error("Capture before sixteenth rise");
	a_first_edge: assert property (@(posedge CLOCK) disable iff (RST)
		mode == ICC_MODE_EDGE_FIRST && !s_q.first_done && fifo_push
		|-> (s_q.control[BIT_FIRST_EDGE] ? rise : fall))
		else $error("First capture on wrong edge");
	a_buffer_read: assert property (@(posedge CLOCK) disable iff (RST)
		s_q.ph_valid && !s_q.ph_write && s_q.ph_addr == ADDR_BUFFER && $past(!fifo_empty)
		|-> HRDATA == $past(fifo_head))
		else $error("Buffer read not oldest value");
	a_overflow_hold: assert property (@(posedge CLOCK) disable iff (RST)
		s_q.overflow && enabled |=> s_q.overflow)
		else $error("Overflow flag lost while enabled");
	a_overflow_read: assert property (@(posedge CLOCK) disable iff (RST)
		s_q.ph_valid && !s_q.ph_write && s_q.ph_addr == ADDR_CONTROL
		|-> HRDATA[BIT_OVERFLOW] == $past(s_q.overflow))
		else $error("Overflow flag read wrong");
	a_clear_loses: assert property (@(posedge CLOCK) disable iff (RST)
		s_q.ph_valid && s_q.ph_write && s_q.ph_addr == ADDR_IRQ_CLEAR && fifo_push && fifo_full
		|=> s_q.irq_status[IRQ_OVERFLOW])
		else $error("Clear beat same-cycle overflow");
	a_wake_idle: assert property (@(posedge CLOCK) disable iff (RST)
		qualify && DEVICE_IDLE |=> WAKE_REQUEST)
		else $error("No wake on capture in Idle");
	a_off_quiet: assert property (@(posedge CLOCK) disable iff (RST)
		!enabled |-> !qualify && !fifo_push)
		else $error("Capture while disabled");
endmodule // icc_top
`default_nettype wire

//--- core/icc_pkg.sv
package icc_pkg;
	// ========================================
	// Register map (byte addresses on the bus)
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_BUFFER = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
	localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;
	// ========================================
	// Control register fields
	localparam int BIT_ENABLE = 15;
	localparam int BIT_STOP_IN_IDLE = 13;
	localparam int BIT_FIRST_EDGE = 9;
	localparam int BIT_WIDE = 8;
	localparam int BIT_TIMEBASE = 7;
	localparam int BIT_EPI_HI = 6;
	localparam int BIT_EPI_LO = 5;
	localparam int BIT_OVERFLOW = 4;
	localparam int BIT_NOT_EMPTY = 3;
	localparam logic [31:0] CONTROL_WRITE_MASK = 32'h0000_a3e7;
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
	// ========================================
	// Interrupt status bits
	localparam int IRQ_CAPTURE = 0;
	localparam int IRQ_OVERFLOW = 1;
	localparam int IRQ_BITS = 2;
	// ========================================
	// Buffer and prescaler
	localparam int FIFO_DEPTH = 4;
	localparam logic [2:0] FIFO_DEPTH_COUNT = 3'h4;
	localparam logic [3:0] PRESCALE_4_LAST = 4'h3;
	localparam logic [3:0] PRESCALE_16_LAST = 4'hf;
	typedef enum logic [2:0] {
		ICC_MODE_OFF = 3'h0,
		ICC_MODE_EVERY_EDGE = 3'h1,
		ICC_MODE_FALLING = 3'h2,
		ICC_MODE_RISING = 3'h3,
		ICC_MODE_RISE_4 = 3'h4,
		ICC_MODE_RISE_16 = 3'h5,
		ICC_MODE_EDGE_FIRST = 3'h6,
		ICC_MODE_INT_ONLY = 3'h7
	} icc_mode_t;
endpackage

//--- core/icc_sync.sv
`timescale 1ns/1ns
`default_nettype none
module icc_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic din,
	output logic dout
);
	typedef struct packed {
		logic meta;
		logic stable;
	} icc_sync_t;
	icc_sync_t s_q, s_d;
	always_comb begin
		s_d.meta = din;
		s_d.stable = s_q.meta;
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign dout = s_q.stable;
endmodule // icc_sync
`default_nettype wire

//--- core/icc_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module icc_fifo
	import icc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic flush,
	input wire logic push,
	input wire logic [31:0] push_data,
	input wire logic pop,
	output logic [31:0] head,
	output logic empty,
	output logic full
);
	typedef struct packed {
		logic [FIFO_DEPTH-1:0][31:0] mem;
		logic [1:0] rd;
		logic [1:0] wr;
		logic [2:0] count;
	} icc_fifo_t;
	icc_fifo_t f_q, f_d;
	logic do_push;
	logic do_pop;
	always_comb begin
		f_d = f_q;
		do_push = push && (f_q.count != FIFO_DEPTH_COUNT);
		do_pop = pop && (f_q.count != 3'h0);
		if (flush) begin
			f_d.rd = 2'h0;
			f_d.wr = 2'h0;
			f_d.count = 3'h0;
		end else begin
			if (do_push) begin
				f_d.mem[f_q.wr] = push_data;
				f_d.wr = f_q.wr + 2'h1;
			end
			if (do_pop) begin
				f_d.rd = f_q.rd + 2'h1;
			end
			if (do_push && !do_pop) begin
				f_d.count = f_q.count + 3'h1;
			end else if (do_pop && !do_push) begin
				f_d.count = f_q.count - 3'h1;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			f_q <= '0;
		end else begin
			f_q <= f_d;
		end
	end
	assign head = f_q.mem[f_q.rd];
	assign empty = (f_q.count == 3'h0);
	assign full = (f_q.count == FIFO_DEPTH_COUNT);
endmodule // icc_fifo
`default_nettype wire

//--- verification/icc_pin_src.sv
`timescale 1ns/1ns
`default_nettype none
// ========================================
// Signal source on the capture pin
module icc_pin_src (
	input wire logic clk,
	output logic pin
);
	initial pin = 1'b0;
	// Each level holds three clocks so the two-flop synchroniser never misses an edge
	task automatic pulses(input int n);
		repeat (n) begin
			pin <= 1'b1;
			repeat (3) @(posedge clk);
			pin <= 1'b0;
			repeat (3) @(posedge clk);
		end
		repeat (3) @(posedge clk);
	endtask
endmodule // icc_pin_src
`default_nettype wire

//--- verification/icc_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module icc_tb_top;
	import icc_pkg::*;
	logic clock = 0, rst = 1, hsel = 0, hwrite = 0, idle = 0, sleep = 0, hready, pin, irq, wake;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, c, r, hrdata;
	logic [2:0] hsize = 3'h2;
	logic hresp;
	logic [15:0] t1 = 16'h0, t2 = 16'h0;
	logic [2:0] md [4] = '{3'h1, 3'h2, 3'h3, 3'h6};
	int num_errors = 0, tests_run = 0, seed = 75, wakes = 0, n;
	initial forever #2 clock = ~clock;
	icc_top icc_top_i(.CLOCK(clock), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
		.HREADYOUT(hready), .HRESP(hresp), .CAPTURE_INPUT_PIN(pin), .FIRST_TIMEBASE(t1),
		.SECOND_TIMEBASE(t2), .DEVICE_IDLE(idle), .DEVICE_SLEEP(sleep), .CAPTURE_IRQ(irq),
		.WAKE_REQUEST(wake));
	icc_pin_src icc_pin_src_i(.clk(clock), .pin(pin));
	always @(posedge clock) if (wake === 1'b1) wakes++;
	// ========================================
	// Checking and bus tasks
	task automatic complete_run();
		if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_ready();
		int k;
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (hready !== 1'b1 && k < 100);
		if (hready !== 1'b1) begin
			chk(32'h0, 32'h1);
			complete_run();
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task automatic setcfg(input logic [31:0] v);
		bus(1'b1, ADDR_CONTROL, 32'h0);
		@(posedge clock); // Idle cycle after disable
		bus(1'b1, ADDR_CONTROL, v);
		c = v;
	endtask
	function automatic logic [31:0] expv();
		if (c[BIT_WIDE]) return {t2, t1};
		return c[BIT_TIMEBASE] ? {16'h0, t1} : {16'h0, t2};
	endfunction
	function automatic int ncap();
		return (c[2:0] == 3'h1 || (c[2:0] == 3'h6 && c[BIT_FIRST_EDGE])) ? 2 : 1;
	endfunction
	// ========================================
	// Main sequence
	initial begin
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		rdchk(ADDR_CONTROL, CONTROL_RESET);
		bus(1'b1, ADDR_CONTROL, 32'hffff_ffe0);
		rdchk(ADDR_CONTROL, 32'h0000_a3e0);
		rdchk(8'h20, 32'h0);
		for (int i = 0; i < 32; i++) begin
			r = $random(seed);
			t1 <= r[15:0];
			t2 <= r[31:16];
			r = $random(seed);
			setcfg(32'h0000_8000 | (r & 32'h0000_0380) | {29'h0, md[i % 4]});
			icc_pin_src_i.pulses(1);
			n = ncap();
			repeat (n) rdchk(ADDR_BUFFER, expv());
			rdchk(ADDR_CONTROL, c);
		end
		for (int p = 0; p < 2; p++) begin
			setcfg(p ? 32'h0000_8085 : 32'h0000_8084);
			icc_pin_src_i.pulses(p ? 15 : 3);
			rdchk(ADDR_CONTROL, c);
			icc_pin_src_i.pulses(1);
			rdchk(ADDR_BUFFER, expv());
		end
		setcfg(32'h0000_8083);
		for (int k = 0; k < 5; k++) begin
			t1 <= 16'(k + 1);
			icc_pin_src_i.pulses(1);
		end
		rdchk(ADDR_CONTROL, c | 32'h18);
		rdchk(ADDR_IRQ_STATUS, 32'h3);
		for (int k = 0; k < 4; k++) rdchk(ADDR_BUFFER, 32'(k + 1));
		rdchk(ADDR_CONTROL, c | 32'h10);
		setcfg(c);
		rdchk(ADDR_CONTROL, c);
		bus(1'b1, ADDR_IRQ_ENABLE, 32'h1);
		for (int e = 0; e < 4; e++) begin
			setcfg(32'h0000_8003 | (32'(e) << 5));
			bus(1'b1, ADDR_IRQ_CLEAR, 32'h3);
			icc_pin_src_i.pulses(e);
			chk({31'h0, irq}, 32'h0);
			icc_pin_src_i.pulses(1);
			chk({31'h0, irq}, 32'h1);
			bus(1'b1, ADDR_IRQ_ENABLE, 32'h0);
			repeat (2) @(posedge clock);
			chk({31'h0, irq}, 32'h0);
			bus(1'b1, ADDR_IRQ_ENABLE, 32'h1);
			bus(1'b1, ADDR_IRQ_CLEAR, 32'h1);
			repeat (2) @(posedge clock);
			chk({31'h0, irq}, 32'h0);
		end
		setcfg(32'h0000_8007);
		icc_pin_src_i.pulses(1);
		chk({31'h0, irq}, 32'h1);
		rdchk(ADDR_IRQ_STATUS, 32'h1);
		rdchk(ADDR_CONTROL, c);
		bus(1'b1, ADDR_IRQ_CLEAR, 32'h1);
		chk(32'(wakes), 32'h0);
		setcfg(32'h0000_a003);
		idle <= 1'b1;
		icc_pin_src_i.pulses(1);
		rdchk(ADDR_CONTROL, c);
		setcfg(32'h0000_8003);
		wakes = 0;
		icc_pin_src_i.pulses(1);
		chk(32'(wakes), 32'h1);
		idle <= 1'b0;
		sleep <= 1'b1;
		icc_pin_src_i.pulses(1);
		chk(32'(wakes), 32'h2);
		sleep <= 1'b0;
		rdchk(ADDR_CONTROL, c | 32'h8);
		complete_run();
	end
endmodule // icc_tb_top
`default_nettype wire
